// ===== design/mfrc_core.v
// Multi-IO read command front end of a serial flash
`timescale 1ns/1ps
`include "mfrc_regs.vh"
module mfrc_core (
    input  wire        sys_clk,             // 40 MHz system clock
    input  wire        rst,                 // Synchronous reset, active high
    input  wire        spi_sclk,            // Serial clock from host
    input  wire        spi_cs_n,            // Chip select, active low
    input  wire [3:0]  io_in,               // Serial lines zero to three, input
    output wire [3:0]  io_out,              // Serial lines, output value
    output wire [3:0]  io_oe,               // Serial lines, output enable
    input  wire        quad_io_enable_bit,  // Quad IO enable status bit
    output wire [23:0] mem_addr,            // Array byte address
    output wire        mem_rd,              // Array read strobe, one cycle
    input  wire [7:0]  mem_rdata,           // Array data, valid in the strobe cycle
    output wire        continuation_active, // Next frame skips its opcode
    output wire        wrap_disable_bit,    // Stored wrap disable bit
    output wire [1:0]  wrap_length_select   // Stored wrap length code
);
    localparam ST_OPCODE = 3'h0;
    localparam ST_ADDR   = 3'h1;
    localparam ST_MODE   = 3'h2;
    localparam ST_DUMMY  = 3'h3;
    localparam ST_DATA   = 3'h4;
    localparam ST_IGNORE = 3'h5;

    wire [5:0] pins_s;
    mfrc_sync #(.W(6)) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({~spi_cs_n, spi_sclk, io_in}), // Inverted: cleared flop reads deselected
        .sync_out (pins_s)
    );
    wire       cs_s   = ~pins_s[5];
    wire       sclk_s = pins_s[4];
    wire [3:0] io_s   = pins_s[3:0];

    reg        sclk_d_q;
    reg [2:0]  st_q;
    reg [4:0]  cnt_q;
    reg [1:0]  gcnt_q;
    reg [7:0]  cmd_q;
    reg [23:0] sr_q;
    reg [23:0] addr_q;
    reg [23:0] mem_addr_q;
    reg        mem_rd_q;
    reg        tgt_sh_q;
    reg        pre_q;
    reg [7:0]  sh_q;
    reg [7:0]  nxt_q;
    reg [3:0]  io_out_q;
    reg [3:0]  io_oe_q;
    reg        cont_q;
    reg        wrap_dis_q;
    reg [1:0]  wrap_len_q;

    wire rise = sclk_s & ~sclk_d_q;
    wire fall = ~sclk_s & sclk_d_q;

    function [2:0] addr_lanes;
        input [7:0] op;
        begin
            case (op)
                `MFRC_OP_DUAL_IO:   addr_lanes = 3'h2;
                `MFRC_OP_QUAD_IO,
                `MFRC_OP_WORD_QUAD,
                `MFRC_OP_SET_WRAP:  addr_lanes = 3'h4;
                default:            addr_lanes = 3'h1;
            endcase
        end
    endfunction

    function [23:0] shin;
        input [23:0] sr;
        input [2:0]  w;
        input [3:0]  d;
        begin
            case (w)
                3'h2:    shin = {sr[21:0], d[1], d[0]};
                3'h4:    shin = {sr[19:0], d[3], d[2], d[1], d[0]};
                default: shin = {sr[22:0], d[0]};
            endcase
        end
    endfunction

    function [23:0] adv;
        input [23:0] a;
        input        wrap_on;
        input [1:0]  len;
        reg   [7:0]  m;
        begin
            case (len)
                2'h0:    m = 8'h07;
                2'h1:    m = 8'h0F;
                2'h2:    m = 8'h1F;
                default: m = 8'h3F;
            endcase
            if (wrap_on)
                adv = {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
            else
                adv = a + 24'h000001;
        end
    endfunction

    wire [2:0] aw = addr_lanes(cmd_q);
    wire [2:0] dw = (cmd_q == `MFRC_OP_DUAL_IO) ? 3'h2 : 3'h4;
    wire [4:0] alen = (aw == 3'h4) ? `MFRC_ADDR_CLKS_X4 :
                      (aw == 3'h2) ? `MFRC_ADDR_CLKS_X2 : `MFRC_ADDR_CLKS_X1;
    wire [4:0] mlen = (aw == 3'h4) ? `MFRC_MODE_CLKS_X4 : `MFRC_MODE_CLKS_X2;
    wire [4:0] dlen = (cmd_q == `MFRC_OP_QUAD_OUT)  ? `MFRC_DUMMY_QUAD_OUT :
                      (cmd_q == `MFRC_OP_QUAD_IO)   ? `MFRC_DUMMY_QUAD_IO :
                      (cmd_q == `MFRC_OP_WORD_QUAD) ? `MFRC_DUMMY_WORD_QUAD :
                      5'h00;
    wire wrap_on = ~wrap_dis_q & ((cmd_q == `MFRC_OP_QUAD_IO) |
                                  (cmd_q == `MFRC_OP_WORD_QUAD));
    wire [7:0]  op_w  = {sr_q[6:0], io_s[0]};
    wire [23:0] sr_w  = shin(sr_q, aw, io_s);
    wire        op_ok = (op_w == `MFRC_OP_DUAL_IO) |
                        (quad_io_enable_bit & ((op_w == `MFRC_OP_QUAD_OUT) |
                                               (op_w == `MFRC_OP_QUAD_IO) |
                                               (op_w == `MFRC_OP_WORD_QUAD) |
                                               (op_w == `MFRC_OP_SET_WRAP)));
    wire [1:0]  glast = (dw == 3'h4) ? 2'h1 : 2'h3;

    always @(posedge sys_clk) begin
        if (rst) begin
            sclk_d_q   <= 1'b0;
            st_q       <= ST_OPCODE;
            cnt_q      <= 5'h00;
            gcnt_q     <= 2'h0;
            cmd_q      <= 8'h00;
            sr_q       <= 24'h000000;
            addr_q     <= 24'h000000;
            mem_addr_q <= 24'h000000;
            mem_rd_q   <= 1'b0;
            tgt_sh_q   <= 1'b0;
            pre_q      <= 1'b0;
            sh_q       <= 8'h00;
            nxt_q      <= 8'h00;
            io_out_q   <= 4'h0;
            io_oe_q    <= 4'h0;
            cont_q     <= 1'b0;
            wrap_dis_q <= `MFRC_WRAP_DIS_RST;
            wrap_len_q <= `MFRC_WRAP_LEN_RST;
        end else begin
            sclk_d_q <= sclk_s;
            mem_rd_q <= 1'b0;
            // Fetched byte lands in the current or the next-byte buffer
            if (mem_rd_q) begin
                if (tgt_sh_q)
                    sh_q <= mem_rdata;
                else
                    nxt_q <= mem_rdata;
            end
            if (pre_q) begin
                pre_q      <= 1'b0;
                mem_rd_q   <= 1'b1;
                tgt_sh_q   <= 1'b0;
                mem_addr_q <= addr_q;
                addr_q     <= adv(addr_q, wrap_on, wrap_len_q);
            end
            if (cs_s) begin
                st_q    <= cont_q ? ST_ADDR : ST_OPCODE;
                cnt_q   <= 5'h00;
                gcnt_q  <= 2'h0;
                pre_q   <= 1'b0;
                io_oe_q <= 4'h0;
            end else if (rise) begin
                case (st_q)
                    ST_OPCODE: begin
                        sr_q <= shin(sr_q, 3'h1, io_s);
                        if (cnt_q == `MFRC_OPCODE_CLKS - 5'h01) begin
                            cnt_q <= 5'h00;
                            cmd_q <= op_w;
                            st_q  <= op_ok ? ST_ADDR : ST_IGNORE;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_ADDR: begin
                        sr_q <= sr_w;
                        if (cnt_q == alen - 5'h01) begin
                            cnt_q  <= 5'h00;
                            addr_q <= sr_w;
                            st_q   <= (cmd_q == `MFRC_OP_QUAD_OUT) ? ST_DUMMY : ST_MODE;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_MODE: begin
                        sr_q <= sr_w;
                        if (cnt_q == mlen - 5'h01) begin
                            cnt_q <= 5'h00;
                            if (cmd_q == `MFRC_OP_SET_WRAP) begin
                                wrap_dis_q <= sr_w[`MFRC_WRAP_DIS_POS];
                                wrap_len_q <= sr_w[`MFRC_WRAP_LEN_HI:`MFRC_WRAP_LEN_LO];
                                st_q       <= ST_IGNORE;
                            end else begin
                                // Low nibble never looked at; all-ones byte drops the mode
                                cont_q <= (sr_w[`MFRC_CONT_SEL_HI:`MFRC_CONT_SEL_LO] ==
                                           `MFRC_CONT_KEEP);
                                if (dlen == 5'h00) begin
                                    st_q       <= ST_DATA;
                                    mem_rd_q   <= 1'b1;
                                    tgt_sh_q   <= 1'b1;
                                    pre_q      <= 1'b1;
                                    mem_addr_q <= addr_q;
                                    addr_q     <= adv(addr_q, wrap_on, wrap_len_q);
                                end else begin
                                    st_q <= ST_DUMMY;
                                end
                            end
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_DUMMY: begin
                        // Lines are not sampled here
                        if (cnt_q == dlen - 5'h01) begin
                            cnt_q      <= 5'h00;
                            st_q       <= ST_DATA;
                            mem_rd_q   <= 1'b1;
                            tgt_sh_q   <= 1'b1;
                            pre_q      <= 1'b1;
                            mem_addr_q <= addr_q;
                            addr_q     <= adv(addr_q, wrap_on, wrap_len_q);
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (fall && st_q == ST_DATA) begin
                // Drive only from the first data falling edge, host has floated by then
                io_oe_q  <= (dw == 3'h4) ? 4'hF : 4'h3;
                io_out_q <= (dw == 3'h4) ? sh_q[7:4] : {2'h0, sh_q[7:6]};
                if (gcnt_q == glast) begin
                    gcnt_q     <= 2'h0;
                    sh_q       <= nxt_q;
                    mem_rd_q   <= 1'b1;
                    tgt_sh_q   <= 1'b0;
                    mem_addr_q <= addr_q;
                    addr_q     <= adv(addr_q, wrap_on, wrap_len_q);
                end else begin
                    gcnt_q <= gcnt_q + 2'h1;
                    sh_q   <= (dw == 3'h4) ? {sh_q[3:0], 4'h0} : {sh_q[5:0], 2'h0};
                end
            end
        end
    end

    assign io_out              = io_out_q;
    assign io_oe               = io_oe_q;
    assign mem_addr            = mem_addr_q;
    assign mem_rd              = mem_rd_q;
    assign continuation_active = cont_q;
    assign wrap_disable_bit    = wrap_dis_q;
    assign wrap_length_select  = wrap_len_q;
endmodule // mfrc_core

// ===== design/mfrc_regs.vh
// Opcodes, phase lengths, field positions and reset values of the multi-IO read front end
`ifndef MFRC_REGS_VH
`define MFRC_REGS_VH

`define MFRC_OP_QUAD_OUT     8'h6B
`define MFRC_OP_DUAL_IO      8'hBB
`define MFRC_OP_QUAD_IO      8'hEB
`define MFRC_OP_WORD_QUAD    8'hE7
`define MFRC_OP_SET_WRAP     8'h77

`define MFRC_OPCODE_CLKS     5'h08
`define MFRC_ADDR_CLKS_X1    5'h18
`define MFRC_ADDR_CLKS_X2    5'h0C
`define MFRC_ADDR_CLKS_X4    5'h06
`define MFRC_MODE_CLKS_X2    5'h04
`define MFRC_MODE_CLKS_X4    5'h02
`define MFRC_DUMMY_QUAD_OUT  5'h08
`define MFRC_DUMMY_QUAD_IO   5'h04
`define MFRC_DUMMY_WORD_QUAD 5'h02

`define MFRC_CONT_SEL_HI     5
`define MFRC_CONT_SEL_LO     4
`define MFRC_CONT_KEEP       2'h2
`define MFRC_WRAP_DIS_POS    4
`define MFRC_WRAP_LEN_HI     6
`define MFRC_WRAP_LEN_LO     5
`define MFRC_WRAP_DIS_RST    1'h1
`define MFRC_WRAP_LEN_RST    2'h0

`endif

// ===== design/mfrc_sync.v
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module mfrc_sync #(
    parameter W = 6
) (
    input  wire         sys_clk,  // System clock
    input  wire         rst,      // Synchronous reset, active high
    input  wire [W-1:0] async_in, // Pins from outside the clock domain
    output wire [W-1:0] sync_out  // Synchronised copy
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // mfrc_sync

// ===== testbench/mfrc_core_properties.sv
// Port checks of the multi-IO read front end
`timescale 1ns/1ps
module mfrc_core_checker (
    input wire        sys_clk,             // Clock
    input wire        rst,                 // Reset
    input wire        spi_sclk,            // Serial clock
    input wire        spi_cs_n,            // Chip select
    input wire [3:0]  io_in,               // Lines in
    input wire [3:0]  io_out,              // Lines out
    input wire [3:0]  io_oe,               // Line enables
    input wire        quad_io_enable_bit,  // Quad enable
    input wire [23:0] mem_addr,            // Array address
    input wire        mem_rd,              // Array strobe
    input wire [7:0]  mem_rdata,           // Array data
    input wire        continuation_active, // Opcode skip
    input wire        wrap_disable_bit,    // Wrap off
    input wire [1:0]  wrap_length_select   // Wrap length
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    oe_lanes_a: assert property (io_oe inside {4'h0, 4'h3, 4'hF})
        else $error("illegal lane enable mix");
    quad_gate_a: assert property ($rose(io_oe == 4'hF) |-> quad_io_enable_bit)
        else $error("quad drive without quad enable");
    out_fall_a: assert property ($changed(io_out) |-> $past(!spi_sclk, 2))
        else $error("output changed away from a falling edge");
    oe_frame_a: assert property (io_oe != 4'h0 |-> !$past(spi_cs_n, 5))
        else $error("lines driven outside a frame");
    rd_frame_a: assert property (mem_rd |-> !$past(spi_cs_n, 5))
        else $error("array read outside a frame");
    addr_step_a: assert property (mem_rd && $past(mem_rd) && wrap_disable_bit
        |-> mem_addr == $past(mem_addr) + 24'h1) else $error("address did not advance");
    reset_vals_a: assert property ($fell(rst) |-> wrap_disable_bit &&
        wrap_length_select == 2'h0 && !continuation_active) else $error("bad reset values");
    wrap_gate_a: assert property ($changed({wrap_disable_bit, wrap_length_select})
        |-> quad_io_enable_bit) else $error("wrap setting changed without quad enable");
    cont_frame_a: assert property ($changed(continuation_active)
        |-> !$past(spi_cs_n, 4)) else $error("continuation changed outside a frame");
endmodule // mfrc_core_checker
bind mfrc_core mfrc_core_checker u_chk (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .io_in,
    .io_out, .io_oe, .quad_io_enable_bit, .mem_addr, .mem_rd, .mem_rdata,
    .continuation_active, .wrap_disable_bit, .wrap_length_select);

// ===== testbench/mfrc_core_test.sv
// Self-checking bench of the multi-IO read front end
`timescale 1ns/1ps
`include "mfrc_regs.vh"
module mfrc_core_test;
    reg         sys_clk = 1'b0, rst = 1'b1, quad_io_enable_bit = 1'b1, tog = 1'b0, exp_dis = 1'b1;
    wire [7:0]  mem_rdata;
    reg  [3:0]  q;
    reg  [1:0]  exp_len = 2'h0;
    reg  [7:0]  exp_q[$];
    reg  [7:0]  qops[4] = '{`MFRC_OP_QUAD_OUT, `MFRC_OP_QUAD_IO,
                            `MFRC_OP_WORD_QUAD, `MFRC_OP_SET_WRAP};
    int         bad_count = 0, num_checks = 0, oe_cnt = 0, oe_base = 0;
    integer     seed = 32'he513;
    wire        spi_sclk, spi_cs_n, mem_rd, continuation_active, wrap_disable_bit, rx_valid;
    wire [3:0]  io_out, io_oe, host_do, host_oe, io_in;
    wire [23:0] mem_addr;
    wire [1:0]  wrap_length_select;
    wire [7:0]  rx_byte;
    // Lines nobody drives toggle so a stale value never reads as valid data
    assign io_in = (io_oe & io_out) | (~io_oe & host_oe & host_do) |
                   (~io_oe & ~host_oe & {4{tog}});
    mfrc_core u_dut (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .io_in, .io_out, .io_oe,
        .quad_io_enable_bit, .mem_addr, .mem_rd, .mem_rdata, .continuation_active,
        .wrap_disable_bit, .wrap_length_select);
    mfrc_host_model u_host (.sys_clk, .io_in, .spi_sclk, .spi_cs_n, .host_do, .host_oe,
        .rx_valid, .rx_byte);
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic [7:0] mem_byte(input [23:0] a);
        mem_byte = a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    // Array answers in the strobe cycle, zero otherwise so a mistimed capture shows
    assign mem_rdata = mem_rd ? mem_byte(mem_addr) : 8'h00;
    always @(posedge sys_clk) begin
        tog <= ~tog;
        if (io_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) check(rx_byte, 32'h1FF);
            else check(rx_byte, exp_q.pop_front());
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rd(input [7:0] op, input bit skip, input [23:0] a, input [7:0] md, input int n);
        int al, dm, len;
        reg [23:0] p;
        al = (op == `MFRC_OP_QUAD_OUT) ? 1 : (op == `MFRC_OP_DUAL_IO) ? 2 : 4;
        dm = (op == `MFRC_OP_QUAD_OUT) ? 8 : (op == `MFRC_OP_QUAD_IO) ? 4 : (al == 4) ? 2 : 0;
        len = 8 << exp_len;
        p = a;
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem_byte(p));
            if (exp_dis == 1'b0 && al == 4 && dm < 8)
                p = 24'((p & ~(len - 1)) | ((p + 1) & (len - 1)));
            else p = p + 24'h1;
        end
        u_host.open_frame;
        if (!skip) u_host.send(1, 8, op);
        u_host.send(al, 24 / al, a);
        if (al > 1) u_host.send(al, 8 / al, md);
        if (dm > 0) u_host.send(al, dm, $random(seed));
        u_host.recv(al == 2 ? 2 : 4, n);
        u_host.close_frame;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(`MFRC_OP_QUAD_OUT, 1'b0, 24'($random(seed)), 8'h00, 4);
        $display("quad output read done");
        for (int m = 2; m <= 4; m += 2) begin
            rd(m == 2 ? `MFRC_OP_DUAL_IO : `MFRC_OP_QUAD_IO, 1'b0, 24'($random(seed)), 8'hE1, 2);
            rd(m == 2 ? `MFRC_OP_DUAL_IO : `MFRC_OP_QUAD_IO, 1'b1, 24'($random(seed)), 8'h2C, 2);
            check(continuation_active, 1);
            u_host.open_frame;
            u_host.send(m, 32 / m, 32'hFFFFFFFF);
            u_host.close_frame;
            check(continuation_active, 0);
        end
        rd(`MFRC_OP_DUAL_IO, 1'b0, 24'($random(seed)), 8'h2C, 1);
        rd(`MFRC_OP_DUAL_IO, 1'b1, 24'($random(seed)), 8'h35, 2);
        check(continuation_active, 0);
        $display("continuation reads done");
        for (int l = 0; l < 5; l++) begin
            u_host.open_frame;
            u_host.send(1, 8, `MFRC_OP_SET_WRAP);
            u_host.send(4, 6, $random(seed));
            u_host.send(4, 2, l < 4 ? 8'h0F | 8'(l << 5) : 8'h10);
            u_host.close_frame;
            exp_dis = (l == 4);
            exp_len = 2'(l % 4);
            check(wrap_disable_bit, l / 4);
            check(wrap_length_select, l % 4);
            rd(l[0] ? `MFRC_OP_WORD_QUAD : `MFRC_OP_QUAD_IO, 1'b0,
               24'($random(seed)) & 24'hFFFFFE, 8'h00, (8 << (l % 4)) + 3);
        end
        $display("wrap reads done");
        quad_io_enable_bit <= 1'b0;
        foreach (qops[i]) begin
            oe_base = oe_cnt;
            u_host.open_frame;
            u_host.send(1, 8, qops[i]);
            u_host.send(4, 8, 32'h0000004F);
            repeat (8) u_host.tick(4'h0, 4'h0, q);
            u_host.close_frame;
            check(oe_cnt - oe_base, 0);
            check(wrap_disable_bit, 1);
        end
        $display("refused commands done");
        repeat (20) @(posedge sys_clk);
        check(exp_q.size(), 0);
        tally_and_finish;
    end
endmodule // mfrc_core_test

// ===== testbench/mfrc_host_model.sv
// Behavioural SPI host that frames the multi-IO read commands
`timescale 1ns/1ps
module mfrc_host_model (
    input  wire       sys_clk,  // System clock
    input  wire [3:0] io_in,    // Resolved serial lines
    output reg        spi_sclk, // Serial clock, still outside frames
    output reg        spi_cs_n, // Chip select, active low
    output reg  [3:0] host_do,  // Line values driven by the host
    output reg  [3:0] host_oe,  // Line enables of the host
    output reg        rx_valid, // Received byte strobe
    output reg  [7:0] rx_byte   // Received byte
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        host_do = 4'h0;
        host_oe = 4'h0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Mode 0 clock: lines change at the fall, device samples at the rise
    task automatic tick(input [3:0] oe, input [3:0] d, output [3:0] q);
        spi_sclk <= 1'b0;
        host_oe <= oe;
        host_do <= d;
        repeat (4) @(posedge sys_clk);
        spi_sclk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        q = io_in;
    endtask
    task automatic send(input int lanes, input int clks, input [31:0] val);
        reg [31:0] v;
        reg [3:0]  q;
        v = val << (32 - lanes * clks);
        for (int i = 0; i < clks; i++) begin
            tick(4'(1 << lanes) - 4'h1, 4'(v[31:28] >> (4 - lanes)), q);
            v = v << lanes;
        end
    endtask
    task automatic recv(input int lanes, input int n);
        reg [7:0] b;
        reg [3:0] q;
        host_oe <= 4'h0;
        @(posedge sys_clk);
        for (int k = 0; k < n; k++) begin
            b = 8'h00;
            for (int i = 0; i < 8 / lanes; i++) begin
                tick(4'h0, 4'h0, q);
                b = 8'((b << lanes) | (q & (4'(1 << lanes) - 4'h1)));
            end
            rx_byte <= b;
            rx_valid <= 1'b1;
            @(posedge sys_clk);
            rx_valid <= 1'b0;
        end
    endtask
    task automatic open_frame;
        spi_cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic close_frame;
        host_oe <= 4'h0;
        spi_sclk <= 1'b0;
        repeat (2) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule // mfrc_host_model
